// ---- hw/ucmcp_defines.svh ----
// Constants for the miscellaneous control pin block
`ifndef UCMCP_DEFINES_SVH
`define UCMCP_DEFINES_SVH

`define UCMCP_SYS_CLK_MHZ 200
`define UCMCP_REF_MHZ 6
`define UCMCP_NDP_W 8
`define UCMCP_NDP_ONE_PORT 8'h01
`define UCMCP_NDP_TWO_PORTS 8'h02
`define UCMCP_MHZ_W 6
`define UCMCP_CLK_OUT_MIN_MHZ 6'h03
`define UCMCP_CLK_OUT_MAX_MHZ 6'h30
`define UCMCP_CLK_OUT_RST_MHZ 6'h0C
`define UCMCP_NCO_W 32
`define UCMCP_NCO_STEP_PER_MHZ 32'h028F5C29
`define UCMCP_LED_OFF_US 50000
`define UCMCP_LED_OFF_CYCLES (`UCMCP_LED_OFF_US * `UCMCP_SYS_CLK_MHZ)
`define UCMCP_REF_TIMEOUT_NS 1000
`define UCMCP_REF_TIMEOUT_CYCLES ((`UCMCP_REF_TIMEOUT_NS * `UCMCP_SYS_CLK_MHZ) / 1000)

`endif

// ---- hw/ucmcp_misc_pins.sv ----
// Miscellaneous control and status pins of the combined host and device controller
// Functional notes
// - Low reset input resets asynchronously
// - Strap 0 reports one port, 1 two
// - Strap changes only the reported count
// - End-of-transfer input has programmable active level
// - Device suspend output follows device controller state
// - Host suspend output follows host controller state
// - High device wake input starts remote wake-up
// - High host wake input resumes host controller
// - Open-drain LED lit, blinks off on traffic
// - Clock output 3 to 48 MHz, 12 after reset
// - Timing derived from 200 MHz system clock; clock output held without 6 MHz reference
// - Independent open-drain power switch per port
// - Sense upstream bus power for attachment
`timescale 1ns/10ps
`default_nettype none
`include "ucmcp_defines.svh"
module ucmcp_misc_pins #(
  parameter int LED_OFF_CYCLES = `UCMCP_LED_OFF_CYCLES,
  parameter int REF_TIMEOUT_CYCLES = `UCMCP_REF_TIMEOUT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic port_count_strap,
  output logic [`UCMCP_NDP_W-1:0] downstream_port_count,
  input wire logic dma_transfer_done_in,
  input wire logic dma_done_active_high,
  output logic dma_transfer_done_pulse,
  input wire logic usb_device_side_suspended,
  input wire logic usb_host_side_suspended,
  output logic device_side_suspend,
  output logic host_side_suspend,
  input wire logic device_side_wake_in,
  input wire logic host_side_wake_in,
  output logic device_remote_wake_req,
  output logic host_resume_req,
  input wire logic usb_traffic,
  input wire logic link_activity_led_in,
  output logic link_activity_led_lvl,
  output logic link_activity_led_oe,
  output logic link_activity_led_seen,
  input wire logic [`UCMCP_MHZ_W-1:0] clk_out_mhz,
  input wire logic clk_out_load,
  output logic [`UCMCP_MHZ_W-1:0] clk_out_mhz_now,
  output logic programmable_clock_out,
  input wire logic oscillator_in,
  output logic oscillator_out,
  output logic reference_alive,
  input wire logic [1:0] port_power_on,
  input wire logic port_one_power_switch_in,
  output logic port_one_power_switch_lvl,
  output logic port_one_power_switch_oe,
  input wire logic port_two_power_switch_in,
  output logic port_two_power_switch_lvl,
  output logic port_two_power_switch_oe,
  output logic [1:0] port_switch_level,
  input wire logic upstream_bus_power_sense,
  output logic upstream_powered
);
  // Strap and count
  logic strap_taken_ff;
  logic [`UCMCP_NDP_W-1:0] port_count_ff;
  // Event edges and suspend state
  logic dma_act_prev_ff;
  logic dma_pulse_ff;
  logic dev_wake_prev_ff;
  logic host_wake_prev_ff;
  logic dev_wake_ff;
  logic host_wake_ff;
  logic dev_susp_ff;
  logic host_susp_ff;
  // LED
  ucmcp_pkg::ucmcp_led_state_t led_state_ff;
  ucmcp_pkg::ucmcp_led_state_t nxt_led_state;
  logic led_oe_ff;
  logic led_lvl_ff;
  logic led_seen_ff;
  logic led_hold;
  // Clock output
  logic osc_prev_ff;
  logic osc_out_ff;
  logic [`UCMCP_MHZ_W-1:0] clk_mhz_ff;
  logic [`UCMCP_NCO_W-1:0] nco_acc_ff;
  logic clk_out_ff;
  logic ref_ok;
  // Power switches and sensing
  logic [1:0] psw_oe_ff;
  logic psw_lvl_ff;
  logic [1:0] psw_level_ff;
  logic vbus_ff;

  wire logic [`UCMCP_NDP_W-1:0] strap_count =
    port_count_strap ? `UCMCP_NDP_TWO_PORTS : `UCMCP_NDP_ONE_PORT;
  wire logic dma_act = (dma_transfer_done_in == dma_done_active_high);
  wire logic dev_wake_rise = device_side_wake_in & ~dev_wake_prev_ff;
  wire logic host_wake_rise = host_side_wake_in & ~host_wake_prev_ff;
  wire logic osc_rise = oscillator_in & ~osc_prev_ff;
  wire logic [`UCMCP_MHZ_W-1:0] clk_mhz_sel =
    (clk_out_mhz < `UCMCP_CLK_OUT_MIN_MHZ) ? `UCMCP_CLK_OUT_MIN_MHZ :
    (clk_out_mhz > `UCMCP_CLK_OUT_MAX_MHZ) ? `UCMCP_CLK_OUT_MAX_MHZ : clk_out_mhz;
  wire logic [`UCMCP_NCO_W-1:0] nco_step =
    {{(`UCMCP_NCO_W-`UCMCP_MHZ_W){1'b0}}, clk_mhz_ff} * `UCMCP_NCO_STEP_PER_MHZ;
  wire logic [`UCMCP_NCO_W:0] nco_sum = {1'b0, nco_acc_ff} + {1'b0, nco_step};
  wire logic nco_carry = nco_sum[`UCMCP_NCO_W];

  // Reference watchdog: stays alive while 6 MHz edges keep arriving
  ucmcp_stretch #(
    .CYCLES(REF_TIMEOUT_CYCLES)
  ) u_ref_watch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trig(osc_rise),
    .active(ref_ok)
  );

  // Keeps the LED dark long enough to be seen after a single packet
  ucmcp_stretch #(
    .CYCLES(LED_OFF_CYCLES)
  ) u_led_hold (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trig(usb_traffic),
    .active(led_hold)
  );

  always_comb begin
    nxt_led_state = led_state_ff;
    unique case (led_state_ff)
      ucmcp_pkg::UCMCP_LED_LIT: begin
        if (usb_traffic) begin
          nxt_led_state = ucmcp_pkg::UCMCP_LED_DARK;
        end
      end
      ucmcp_pkg::UCMCP_LED_DARK: begin
        if (!led_hold && !usb_traffic) begin
          nxt_led_state = ucmcp_pkg::UCMCP_LED_LIT;
        end
      end
    endcase
  end

  // Asynchronous reset: the pin resets the block without a running clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_ff <= 1'b0;
      port_count_ff <= `UCMCP_NDP_ONE_PORT;
      dma_act_prev_ff <= 1'b0;
      dma_pulse_ff <= 1'b0;
      dev_wake_prev_ff <= 1'b0;
      host_wake_prev_ff <= 1'b0;
      dev_wake_ff <= 1'b0;
      host_wake_ff <= 1'b0;
      dev_susp_ff <= 1'b0;
      host_susp_ff <= 1'b0;
    end else begin
      // Strap caught once after release; inputs are quiet during reset
      if (!strap_taken_ff) begin
        port_count_ff <= strap_count;
      end
      strap_taken_ff <= 1'b1;
      dma_act_prev_ff <= dma_act;
      dma_pulse_ff <= dma_act & ~dma_act_prev_ff;
      dev_wake_prev_ff <= device_side_wake_in;
      host_wake_prev_ff <= host_side_wake_in;
      dev_wake_ff <= dev_wake_rise & usb_device_side_suspended;
      host_wake_ff <= host_wake_rise & usb_host_side_suspended;
      dev_susp_ff <= usb_device_side_suspended;
      host_susp_ff <= usb_host_side_suspended;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_state_ff <= ucmcp_pkg::UCMCP_LED_LIT;
      led_oe_ff <= 1'b1;
      led_lvl_ff <= 1'b0;
      led_seen_ff <= 1'b0;
    end else begin
      led_state_ff <= nxt_led_state;
      // Open drain: sinking current lights the LED
      led_oe_ff <= (nxt_led_state == ucmcp_pkg::UCMCP_LED_LIT);
      led_lvl_ff <= 1'b0;
      led_seen_ff <= link_activity_led_in;
    end
  end

  // Clock output by phase accumulator; edges land on the 5 ns grid, so
  // rates that do not divide 100 MHz carry up to one cycle of jitter.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_prev_ff <= 1'b0;
      osc_out_ff <= 1'b0;
      clk_mhz_ff <= `UCMCP_CLK_OUT_RST_MHZ;
      nco_acc_ff <= '0;
      clk_out_ff <= 1'b0;
    end else begin
      osc_prev_ff <= oscillator_in;
      osc_out_ff <= ~oscillator_in;
      if (clk_out_load) begin
        clk_mhz_ff <= clk_mhz_sel;
      end
      // Clock held while the reference is missing
      if (ref_ok) begin
        nco_acc_ff <= nco_sum[`UCMCP_NCO_W-1:0];
        if (nco_carry) begin
          clk_out_ff <= ~clk_out_ff;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      psw_oe_ff <= 2'h0;
      psw_lvl_ff <= 1'b0;
      psw_level_ff <= 2'h0;
      vbus_ff <= 1'b0;
    end else begin
      // Both ports stay live whatever the strap reports
      psw_oe_ff <= port_power_on;
      psw_lvl_ff <= 1'b0;
      psw_level_ff <= {port_two_power_switch_in, port_one_power_switch_in};
      vbus_ff <= upstream_bus_power_sense;
    end
  end

  assign downstream_port_count = port_count_ff;
  assign dma_transfer_done_pulse = dma_pulse_ff;
  assign device_side_suspend = dev_susp_ff;
  assign host_side_suspend = host_susp_ff;
  assign device_remote_wake_req = dev_wake_ff;
  assign host_resume_req = host_wake_ff;
  assign link_activity_led_lvl = led_lvl_ff;
  assign link_activity_led_oe = led_oe_ff;
  assign link_activity_led_seen = led_seen_ff;
  assign clk_out_mhz_now = clk_mhz_ff;
  assign programmable_clock_out = clk_out_ff;
  assign oscillator_out = osc_out_ff;
  assign reference_alive = ref_ok;
  assign port_one_power_switch_lvl = psw_lvl_ff;
  assign port_one_power_switch_oe = psw_oe_ff[0];
  assign port_two_power_switch_lvl = psw_lvl_ff;
  assign port_two_power_switch_oe = psw_oe_ff[1];
  assign port_switch_level = psw_level_ff;
  assign upstream_powered = vbus_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_strap_count;
    $rose(strap_taken_ff) |->
      downstream_port_count == ($past(port_count_strap) ? 8'h02 : 8'h01);
  endproperty
  a_strap_count: assert property (p_strap_count) else $error("port count not from strap");

  property p_strap_frozen;
    strap_taken_ff |=> $stable(downstream_port_count);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("port count changed");

  property p_ports_live;
    port_power_on == 2'h3 |=> port_one_power_switch_oe && port_two_power_switch_oe;
  endproperty
  a_ports_live: assert property (p_ports_live) else $error("port switch not driven");

  property p_dma_done;
    dma_act && !dma_act_prev_ff |=> dma_transfer_done_pulse ##1 !dma_transfer_done_pulse;
  endproperty
  a_dma_done: assert property (p_dma_done) else $error("end of transfer missed");

  property p_dev_susp;
    ##1 device_side_suspend == $past(usb_device_side_suspended);
  endproperty
  a_dev_susp: assert property (p_dev_susp) else $error("device suspend wrong");

  property p_host_susp;
    ##1 host_side_suspend == $past(usb_host_side_suspended);
  endproperty
  a_host_susp: assert property (p_host_susp) else $error("host suspend wrong");

  property p_dev_wake;
    device_remote_wake_req |->
      $past(device_side_wake_in) && $past(usb_device_side_suspended) && !$past(device_side_wake_in, 2);
  endproperty
  a_dev_wake: assert property (p_dev_wake) else $error("spurious device wake");

  property p_host_wake;
    $rose(host_side_wake_in) && usb_host_side_suspended |=> host_resume_req;
  endproperty
  a_host_wake: assert property (p_host_wake) else $error("host resume missed");

  property p_led_off;
    usb_traffic |=> !link_activity_led_oe;
  endproperty
  a_led_off: assert property (p_led_off) else $error("LED not dark on traffic");

  property p_led_stretch;
    $fell(link_activity_led_oe) |-> !link_activity_led_oe [*8];
  endproperty
  a_led_stretch: assert property (p_led_stretch) else $error("LED blink too short");

  property p_clk_range;
    clk_out_mhz_now >= 6'h03 && clk_out_mhz_now <= 6'h30;
  endproperty
  a_clk_range: assert property (p_clk_range) else $error("clock rate out of range");

  property p_ref_hold;
    !reference_alive |=> $stable(programmable_clock_out);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("clock ran without reference");

  property p_vbus;
    ##1 upstream_powered == $past(upstream_bus_power_sense);
  endproperty
  a_vbus: assert property (p_vbus) else $error("bus power sense wrong");

  c_led_blink: cover property ($fell(link_activity_led_oe) ##[1:1000] $rose(link_activity_led_oe));
  c_dma_done: cover property (dma_transfer_done_pulse);
  c_dev_wake: cover property (device_remote_wake_req);
  c_clk_toggle: cover property (reference_alive ##1 $changed(programmable_clock_out));
endmodule // ucmcp_misc_pins
`default_nettype wire

// ---- hw/ucmcp_pkg.sv ----
// Types for the miscellaneous control pin block
package ucmcp_pkg;
  typedef enum logic [0:0] {
    UCMCP_LED_LIT = 1'b0,
    UCMCP_LED_DARK = 1'b1
  } ucmcp_led_state_t;
endpackage

// ---- hw/ucmcp_stretch.sv ----
// Retriggerable hold timer: active for CYCLES clocks after the last trigger
`timescale 1ns/10ps
`default_nettype none
module ucmcp_stretch #(
  parameter int CYCLES = 200,
  parameter int CW = $clog2(CYCLES + 1)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic trig,
  output logic active
);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic active_ff;

  assign nxt_cnt = trig ? CW'(CYCLES) : ((cnt_ff != '0) ? (cnt_ff - 1'b1) : cnt_ff);
  assign active = active_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      active_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      active_ff <= (nxt_cnt != '0);
    end
  end
endmodule // ucmcp_stretch
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the miscellaneous control pin block
`timescale 1ns/10ps
`default_nettype none
`include "ucmcp_defines.svh"
`define CHK(g, e) chk((g), (e))
module testbench;
  localparam int LOFF = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0, dma_in = 1'b0, dma_hi = 1'b1, dsus = 1'b0, hsus = 1'b0;
  logic dwk = 1'b0, hwk = 1'b0, traffic = 1'b0, load = 1'b0, vbus = 1'b0, osc_en = 1'b1;
  logic [5:0] mhz = 6'h00;
  logic [1:0] pwr = 2'h0;
  logic [7:0] cnt;
  logic [5:0] now;
  logic [1:0] psl;
  logic dpul, dsi, hsi, dwr, hrr, led_lvl, led_oe, led_seen, led_in, cko, osc, alive, osc_n;
  logic p1_in, p1_lvl, p1_oe, p2_in, p2_lvl, p2_oe, upw;
  int err_count = 0;
  int check_count = 0;
  int seed, n, nd, nh;
  logic prev;
  logic [5:0] tbl [5];
  always #2.5 sys_clk = ~sys_clk;
  ucmcp_misc_pins #(.LED_OFF_CYCLES(LOFF), .REF_TIMEOUT_CYCLES(200)) ucmcp_misc_pins_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .port_count_strap(strap), .downstream_port_count(cnt),
    .dma_transfer_done_in(dma_in), .dma_done_active_high(dma_hi),
    .dma_transfer_done_pulse(dpul), .usb_device_side_suspended(dsus),
    .usb_host_side_suspended(hsus), .device_side_suspend(dsi), .host_side_suspend(hsi),
    .device_side_wake_in(dwk), .host_side_wake_in(hwk), .device_remote_wake_req(dwr),
    .host_resume_req(hrr), .usb_traffic(traffic), .link_activity_led_in(led_in),
    .link_activity_led_lvl(led_lvl), .link_activity_led_oe(led_oe),
    .link_activity_led_seen(led_seen), .clk_out_mhz(mhz), .clk_out_load(load),
    .clk_out_mhz_now(now), .programmable_clock_out(cko), .oscillator_in(osc),
    .oscillator_out(osc_n), .reference_alive(alive), .port_power_on(pwr),
    .port_one_power_switch_in(p1_in), .port_one_power_switch_lvl(p1_lvl),
    .port_one_power_switch_oe(p1_oe), .port_two_power_switch_in(p2_in),
    .port_two_power_switch_lvl(p2_lvl), .port_two_power_switch_oe(p2_oe),
    .port_switch_level(psl), .upstream_bus_power_sense(vbus), .upstream_powered(upw));
  ucmcp_board_model ucmcp_board_model_inst (
    .rst_n(rst_n), .osc_en(osc_en), .oscillator_in(osc), .led_lvl(led_lvl), .led_oe(led_oe),
    .led_in(led_in), .p1_lvl(p1_lvl), .p1_oe(p1_oe), .p1_in(p1_in), .p2_lvl(p2_lvl),
    .p2_oe(p2_oe), .p2_in(p2_in));
  function automatic logic [5:0] clamp(input logic [5:0] m);
    return (m < 6'h03) ? 6'h03 : ((m > 6'h30) ? 6'h30 : m);
  endfunction
  // Clock edges per 1000 cycles of 5 ns for a rate in MHz
  function automatic int toggles(input logic [5:0] m);
    return int'(m) * 10;
  endfunction
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    step();
    {dsus, hsus, dwk, hwk, traffic, load, vbus, pwr} = '0;
    dma_in = ~dma_hi;
    rst_n = 1'b0;
    strap = s;
    #1;
    `CHK({cnt, led_oe, now}, {8'h01, 1'b1, 6'h0C});
    repeat (12) step();
    rst_n = 1'b1;
    repeat (2) step();
  endtask
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    seed = 178;
    do_reset(1'b0);
    `CHK(cnt, 8'h01);
    `CHK(led_seen, 1'b0);
    repeat (100) step();
    `CHK(alive, 1'b1);
    for (int i = 0; i < 30; i++) begin
      {dsus, hsus, vbus, pwr} = 5'($random(seed));
      step();
      `CHK({dsi, hsi}, {dsus, hsus});
      `CHK({p2_oe, p1_oe}, pwr);
      `CHK(upw, vbus);
      step();
      `CHK(psl, 2'(~pwr));
    end
    for (int p = 0; p < 2; p++) begin
      dma_hi = p[0];
      dma_in = ~p[0];
      repeat (2) step();
      dma_in = p[0];
      n = 0;
      repeat (6) begin
        step();
        n += int'(dpul);
      end
      `CHK(n, 1);
      dma_in = ~p[0];
      step();
    end
    for (int w = 0; w < 2; w++) begin
      {dsus, hsus} = {2{w[0]}};
      repeat (2) step();
      {dwk, hwk} = 2'b11;
      {nd, nh} = '0;
      // Wake held high must give a single request while suspended, none otherwise
      repeat (6) begin
        step();
        nd += int'(dwr);
        nh += int'(hrr);
      end
      `CHK(nd, w);
      `CHK(nh, w);
      {dwk, hwk} = 2'b00;
      step();
    end
    for (int k = 0; k < 2; k++) begin
      traffic = 1'b1;
      step();
      traffic = 1'b0;
      `CHK(led_oe, 1'b0);
      if (k == 0) begin
        repeat (10) step();
        `CHK(led_seen, 1'b1);
      end
    end
    n = 1;
    while (led_oe !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    `CHK(n >= LOFF && n <= LOFF + 3, 1'b1);
    tbl = '{6'h30, 6'h01, 6'h3F, 6'h0C, 6'($random(seed))};
    foreach (tbl[j]) begin
      mhz = tbl[j];
      load = 1'b1;
      step();
      load = 1'b0;
      `CHK(now, clamp(tbl[j]));
      n = 0;
      prev = cko;
      repeat (1000) begin
        step();
        n += int'(cko !== prev);
        prev = cko;
      end
      `CHK(n >= toggles(clamp(tbl[j])) - 3 && n <= toggles(clamp(tbl[j])) + 3, 1'b1);
    end
    // Without a reference the output must stand still
    osc_en = 1'b0;
    repeat (260) step();
    `CHK(alive, 1'b0);
    `CHK(osc_n, !osc);
    n = 0;
    prev = cko;
    repeat (50) begin
      step();
      n += int'(cko !== prev);
    end
    `CHK(n, 0);
    osc_en = 1'b1;
    do_reset(1'b1);
    `CHK(cnt, 8'h02);
    pwr = 2'b01;
    step();
    `CHK({p2_oe, p1_oe}, 2'b01);
    final_report();
  end
endmodule // testbench
`default_nettype wire

// ---- tb/ucmcp_board_model.sv ----
// Board side: crystal reference and pull-ups on the open-drain pins
`timescale 1ns/10ps
`default_nettype none
module ucmcp_board_model #(
  parameter real HALF_NS = 83.34
) (
  input wire logic rst_n,
  input wire logic osc_en,
  output logic oscillator_in,
  input wire logic led_lvl,
  input wire logic led_oe,
  output logic led_in,
  input wire logic p1_lvl,
  input wire logic p1_oe,
  output logic p1_in,
  input wire logic p2_lvl,
  input wire logic p2_oe,
  output logic p2_in
);
  // Reference stands still in reset so no input toggles then; the odd 10 ps
  // start with an even half period keeps crystal edges off the clock edges
  initial begin
    oscillator_in = 1'b0;
    #0.01;
    forever #(HALF_NS) oscillator_in = (rst_n && osc_en) ? ~oscillator_in : oscillator_in;
  end
  // Released pins rise through the board pull-ups
  assign led_in = led_oe ? led_lvl : 1'b1;
  assign p1_in = p1_oe ? p1_lvl : 1'b1;
  assign p2_in = p2_oe ? p2_lvl : 1'b1;
endmodule // ucmcp_board_model
`default_nettype wire
